/* hw/lps_defs.svh */
// constants of the pixel serializer and palette block
// Behaviour
// R01: FIFO holds 512 words, halved per panel dual
// R02: request DMA while word count below threshold
// R03: pixels of 1,2,4,8,16,24 bits from words
// R04: memory ordering selects little or big endian
// R05: little endian: first pixel in low bits
// R06: big endian: first pixel in high bits
// R07: 24-bit pixels packed across word boundaries
// R08: palette use set by panel type, width
// R09: pixel value indexes the lookup table
// R10: lookup table of 256 16-bit entries
// R11: host writes and reads every table entry
// R12: one entry per word, low 16 bits
// R13: host writes table with full words only
// R14: entry: red 4:0, green 9:5, blue 14:10, intensity 15
// R15: monochrome uses red upper four bits
// R16: colour STN uses upper four bits each
// R17: TFT palette uses all five bits
// R18: intensity bit drives lines 18, 10, 2
// R19: TFT palette zeroes lines 17:16, 9:8, 1:0
// R20: panel type selects TFT, mono, colour
`ifndef LPS_DEFS_SVH
`define LPS_DEFS_SVH
`define LPS_FIFO_DEPTH 10'h200
`define LPS_PANEL_DEPTH 10'h100
`define LPS_FIFO_AW 9
`define LPS_LUT_AW 8
`define LPS_LUT_DW 16
`define LPS_ADR_CTRL 12'h000
`define LPS_ADR_STAT 12'h004
`define LPS_LUT_SEL 2'h1
`define LPS_CTRL_WMASK 32'h01ff_00ff
`define LPS_CTRL_RESET 32'h0010_0000
`define LPS_TYPE_MONO 2'h0
`define LPS_TYPE_COLOR 2'h1
`define LPS_TYPE_TFT 2'h2
`define LPS_PW_1 3'h0
`define LPS_PW_2 3'h1
`define LPS_PW_4 3'h2
`define LPS_PW_8 3'h3
`define LPS_PW_16 3'h4
`define LPS_PW_24 3'h5
`endif

/* hw/lps_pkg.sv */
// types of the pixel serializer and palette block
package lps_pkg;
   typedef struct packed {
      logic [6:0] rsvd_hi;
      logic [8:0] fifo_fill_threshold;
      logic [7:0] rsvd_mid;
      logic [1:0] panel_type_sel;
      logic [2:0] pixel_width_sel;
      logic mem_order_sel;
      logic dual_scan;
      logic enable;
   } lps_ctrl_s;
   typedef struct packed {
      logic panel;
      logic [23:0] data;
   } lps_pix_s;
   typedef enum logic [2:0] {
      LPS_BUS_IDLE = 3'b001,
      LPS_BUS_WAIT = 3'b010,
      LPS_BUS_ACK = 3'b100
   } lps_bus_e;
   typedef enum logic [1:0] {
      LPS_F_IDLE = 2'b01,
      LPS_F_WAIT = 2'b10
   } lps_fetch_e;
endpackage : lps_pkg

/* hw/lps_dpram.sv */
// two-port memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module lps_dpram #(
   parameter int AW = 8,
   parameter int DW = 16
) (
   input wire logic clk_i,
   input wire logic a_we_i,
   input wire logic a_re_i,
   input wire logic [AW-1:0] a_addr_i,
   input wire logic [DW-1:0] a_wdata_i,
   output logic [DW-1:0] a_rdata_o,
   input wire logic b_re_i,
   input wire logic [AW-1:0] b_addr_i,
   output logic [DW-1:0] b_rdata_o
);
   logic [DW-1:0] mem_q [2**AW];

   always_ff @(posedge clk_i) begin
      if (a_we_i) begin
         mem_q[a_addr_i] <= a_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (a_re_i) begin
         a_rdata_o <= mem_q[a_addr_i];
      end
   end

   always_ff @(posedge clk_i) begin
      if (b_re_i) begin
         b_rdata_o <= mem_q[b_addr_i];
      end
   end
endmodule : lps_dpram
`default_nettype wire

/* hw/lps_top.sv */
// pixel serializer with input FIFO and palette lookup
`timescale 1ns/1ps
`default_nettype none
`include "lps_defs.svh"
module lps_top
   import lps_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic dma_push_i,
   input wire logic dma_panel_i,
   input wire logic [31:0] dma_data_i,
   output logic [1:0] fifo_full_o,
   output logic [1:0] dma_req_o,
   output logic pix_valid_o,
   output lps_pix_s pix_o,
   input wire logic pix_ready_i
);
   function automatic logic [4:0] px_bits(input logic [2:0] sel);
      case (sel)
         `LPS_PW_1: px_bits = 5'h01;
         `LPS_PW_2: px_bits = 5'h02;
         `LPS_PW_4: px_bits = 5'h04;
         `LPS_PW_8: px_bits = 5'h08;
         `LPS_PW_16: px_bits = 5'h10;
         `LPS_PW_24: px_bits = 5'h18;
         default: px_bits = 5'h01;
      endcase
   endfunction : px_bits

   function automatic logic use_lut(input logic [1:0] pt,
                                    input logic [2:0] sel);
      case (pt)
         `LPS_TYPE_TFT: use_lut = sel <= `LPS_PW_8;
         `LPS_TYPE_MONO: use_lut = sel <= `LPS_PW_2;
         `LPS_TYPE_COLOR: use_lut = sel <= `LPS_PW_8;
         default: use_lut = 1'b0;
      endcase
   endfunction : use_lut

   function automatic logic is_lut(input logic [11:0] adr);
      is_lut = adr[11:10] == `LPS_LUT_SEL;
   endfunction : is_lut

   lps_ctrl_s ctrl_q;
   lps_bus_e bus_st_q;
   lps_fetch_e fetch_st_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic [9:0] cnt_q [2];
   logic [9:0] cnt_nxt [2];
   logic [8:0] wptr_q [2];
   logic [8:0] rptr_q [2];
   logic [1:0] full_q;
   logic [1:0] req_q;
   logic [9:0] cap;
   logic push_pnl;
   logic push_ok;
   logic pop_go;
   logic pop_pnl_q;
   logic [8:0] waddr;
   logic [8:0] raddr;
   logic [31:0] fifo_rdata;
   logic [63:0] acc_q;
   logic [6:0] nbits_q;
   logic word_pnl_q;
   logic [4:0] w;
   logic take;
   logic advance;
   logic [23:0] raw;
   logic s1_valid_q;
   logic [23:0] s1_raw_q;
   logic s1_pnl_q;
   logic s1_pal_q;
   logic out_valid_q;
   lps_pix_s pix_q;
   logic out_tft_pal_q;
   logic out_mono_pal_q;
   logic lut_a_we;
   logic [15:0] lut_a_rdata;
   logic [15:0] lut_b_rdata;
   logic [15:0] e;

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign fifo_full_o = full_q;
   assign dma_req_o = req_q;
   assign pix_valid_o = out_valid_q;
   assign pix_o = pix_q;

   // register bus: request, memory read, answer
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_st_q <= LPS_BUS_IDLE;
         ack_q <= 1'b0;
      end else begin
         case (bus_st_q)
            LPS_BUS_IDLE: begin
               if (wb_cyc_i && wb_stb_i) begin
                  bus_st_q <= LPS_BUS_WAIT;
               end
            end
            LPS_BUS_WAIT: begin
               bus_st_q <= LPS_BUS_ACK;
               ack_q <= 1'b1;
            end
            LPS_BUS_ACK: begin
               bus_st_q <= LPS_BUS_IDLE;
               ack_q <= 1'b0;
            end
            default: begin
               bus_st_q <= LPS_BUS_IDLE;
               ack_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dat_q <= 32'h0;
      end else if (bus_st_q == LPS_BUS_WAIT) begin
         if (is_lut(wb_adr_i)) begin
            dat_q <= {16'h0, lut_a_rdata}; // R11 R12
         end else if (wb_adr_i == `LPS_ADR_CTRL) begin
            dat_q <= ctrl_q;
         end else if (wb_adr_i == `LPS_ADR_STAT) begin
            dat_q <= {full_q[1], full_q[0], req_q[1], req_q[0], 2'h0,
                      cnt_q[1], 6'h0, cnt_q[0]};
         end else begin
            dat_q <= 32'h0;
         end
      end
   end

   // control word, byte lanes honoured
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_q <= lps_ctrl_s'(`LPS_CTRL_RESET);
      end else if (bus_st_q == LPS_BUS_WAIT && wb_we_i &&
                   wb_adr_i == `LPS_ADR_CTRL) begin
         ctrl_q <= lps_ctrl_s'((ctrl_q & ~({{8{wb_sel_i[3]}},
            {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
            & `LPS_CTRL_WMASK)) | (wb_dat_i & {{8{wb_sel_i[3]}},
            {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}}
            & `LPS_CTRL_WMASK));
      end
   end

   // partial writes to the table are dropped
   assign lut_a_we = bus_st_q == LPS_BUS_WAIT && wb_we_i &&
                     is_lut(wb_adr_i) && wb_sel_i == 4'hf; // R13

   lps_dpram #(.AW(`LPS_LUT_AW), .DW(`LPS_LUT_DW)) u_lut ( // R10
      .clk_i(ref_clk_i),
      .a_we_i(lut_a_we),
      .a_re_i(bus_st_q == LPS_BUS_IDLE),
      .a_addr_i(wb_adr_i[9:2]),
      .a_wdata_i(wb_dat_i[15:0]),
      .a_rdata_o(lut_a_rdata),
      .b_re_i(take && use_lut(ctrl_q.panel_type_sel,
                              ctrl_q.pixel_width_sel)),
      .b_addr_i(raw[7:0]), // R09
      .b_rdata_o(lut_b_rdata)
   );

   // input FIFO: one store, split in two for dual scan
   assign cap = ctrl_q.dual_scan ? `LPS_PANEL_DEPTH
                                 : `LPS_FIFO_DEPTH; // R01
   assign push_pnl = ctrl_q.dual_scan & dma_panel_i;
   assign push_ok = dma_push_i && ctrl_q.enable && !full_q[push_pnl];
   assign waddr = ctrl_q.dual_scan ? {push_pnl, wptr_q[push_pnl][7:0]}
                                   : wptr_q[0];
   assign raddr = ctrl_q.dual_scan ? {pop_pnl_q, rptr_q[pop_pnl_q][7:0]}
                                   : rptr_q[0];

   lps_dpram #(.AW(`LPS_FIFO_AW), .DW(32)) u_fifo (
      .clk_i(ref_clk_i),
      .a_we_i(push_ok),
      .a_re_i(1'b0),
      .a_addr_i(waddr),
      .a_wdata_i(dma_data_i),
      .a_rdata_o(),
      .b_re_i(pop_go),
      .b_addr_i(raddr),
      .b_rdata_o(fifo_rdata)
   );

   for (genvar p = 0; p < 2; p++) begin : g_pnl
      logic push_hit;
      logic pop_hit;
      assign push_hit = push_ok && push_pnl == 1'(p);
      assign pop_hit = pop_go && pop_pnl_q == 1'(p);
      assign cnt_nxt[p] = cnt_q[p] + {9'h0, push_hit} - {9'h0, pop_hit};

      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            cnt_q[p] <= 10'h0;
            wptr_q[p] <= 9'h0;
            rptr_q[p] <= 9'h0;
         end else if (!ctrl_q.enable) begin
            cnt_q[p] <= 10'h0;
            wptr_q[p] <= 9'h0;
            rptr_q[p] <= 9'h0;
         end else begin
            cnt_q[p] <= cnt_nxt[p];
            wptr_q[p] <= wptr_q[p] + {8'h0, push_hit};
            rptr_q[p] <= rptr_q[p] + {8'h0, pop_hit};
         end
      end

      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
         if (!reset_n_i) begin
            full_q[p] <= 1'b0;
            req_q[p] <= 1'b0;
         end else begin
            full_q[p] <= ctrl_q.enable && cnt_nxt[p] >= cap; // R01
            req_q[p] <= ctrl_q.enable && (p == 0 || ctrl_q.dual_scan) &&
               cnt_nxt[p] < {1'b0, ctrl_q.fifo_fill_threshold}; // R02
         end
      end
   end

   // serializer: bit reservoir refilled a word at a time
   assign w = px_bits(ctrl_q.pixel_width_sel); // R03
   assign advance = !out_valid_q || pix_ready_i;
   assign take = ctrl_q.enable && advance &&
                 fetch_st_q == LPS_F_IDLE && nbits_q >= {2'h0, w};
   assign pop_go = ctrl_q.enable && fetch_st_q == LPS_F_IDLE &&
                   nbits_q < {2'h0, w} && cnt_q[pop_pnl_q] != 10'h0;
   assign raw = ctrl_q.mem_order_sel ? acc_q[63:40] >> (5'h18 - w) // R06
      : acc_q[23:0] & ((24'h1 << w) - 24'h1); // R05

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fetch_st_q <= LPS_F_IDLE;
         pop_pnl_q <= 1'b0;
         word_pnl_q <= 1'b0;
      end else if (!ctrl_q.enable) begin
         fetch_st_q <= LPS_F_IDLE;
         pop_pnl_q <= 1'b0;
         word_pnl_q <= 1'b0;
      end else begin
         case (fetch_st_q)
            LPS_F_IDLE: begin
               if (pop_go) begin
                  fetch_st_q <= LPS_F_WAIT;
                  word_pnl_q <= pop_pnl_q;
                  pop_pnl_q <= ctrl_q.dual_scan & ~pop_pnl_q;
               end
            end
            LPS_F_WAIT: begin
               fetch_st_q <= LPS_F_IDLE;
            end
            default: begin
               fetch_st_q <= LPS_F_IDLE;
            end
         endcase
      end
   end

   // reservoir keeps leftover bits, so pixels span words
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         acc_q <= 64'h0;
         nbits_q <= 7'h0;
      end else if (!ctrl_q.enable) begin
         acc_q <= 64'h0;
         nbits_q <= 7'h0;
      end else if (fetch_st_q == LPS_F_WAIT) begin
         nbits_q <= nbits_q + 7'h20; // R07
         if (ctrl_q.mem_order_sel) begin
            acc_q <= acc_q | ({fifo_rdata, 32'h0} >> nbits_q); // R06
         end else begin
            acc_q <= acc_q | ({32'h0, fifo_rdata} << nbits_q); // R05
         end
      end else if (take) begin
         nbits_q <= nbits_q - {2'h0, w}; // R03
         if (ctrl_q.mem_order_sel) begin
            acc_q <= acc_q << w; // R04
         end else begin
            acc_q <= acc_q >> w; // R04
         end
      end
   end

   // stage one: raw pixel, table read in flight
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_valid_q <= 1'b0;
         s1_raw_q <= 24'h0;
         s1_pnl_q <= 1'b0;
         s1_pal_q <= 1'b0;
      end else if (!ctrl_q.enable) begin
         s1_valid_q <= 1'b0;
      end else if (advance) begin
         s1_valid_q <= take;
         s1_raw_q <= raw;
         s1_pnl_q <= word_pnl_q;
         s1_pal_q <= use_lut(ctrl_q.panel_type_sel,
                             ctrl_q.pixel_width_sel); // R08
      end
   end

   // stage two: formatting toward the panel data bus
   assign e = lut_b_rdata; // R14
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         out_valid_q <= 1'b0;
         pix_q <= '0;
         out_tft_pal_q <= 1'b0;
         out_mono_pal_q <= 1'b0;
      end else if (!ctrl_q.enable) begin
         out_valid_q <= 1'b0;
      end else if (advance) begin
         out_valid_q <= s1_valid_q;
         if (s1_valid_q) begin
            pix_q.panel <= s1_pnl_q;
            out_tft_pal_q <= s1_pal_q &&
               ctrl_q.panel_type_sel == `LPS_TYPE_TFT;
            out_mono_pal_q <= s1_pal_q &&
               ctrl_q.panel_type_sel == `LPS_TYPE_MONO;
            if (!s1_pal_q) begin
               pix_q.data <= s1_raw_q;
            end else begin
               case (ctrl_q.panel_type_sel) // R20
                  `LPS_TYPE_TFT: pix_q.data <= {e[14:10], e[15], 2'h0,
                     e[9:5], e[15], 2'h0, e[4:0], e[15], 2'h0}; // R17 R18 R19
                  `LPS_TYPE_MONO: pix_q.data <= {20'h0, e[4:1]}; // R15
                  `LPS_TYPE_COLOR: pix_q.data <= {12'h0, e[14:11],
                     e[9:6], e[4:1]}; // R16
                  default: pix_q.data <= s1_raw_q;
               endcase
            end
         end
      end
   end

   property p_fifo_cap;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      cnt_q[0] <= cap && cnt_q[1] <= `LPS_PANEL_DEPTH;
   endproperty
   a_fifo_cap: assert property (p_fifo_cap) // R01
      else $error("fifo count above capacity");

   property p_dma_req;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      ctrl_q.enable && $stable(ctrl_q) |->
         dma_req_o[0] == (cnt_q[0] < {1'b0, ctrl_q.fifo_fill_threshold});
   endproperty
   a_dma_req: assert property (p_dma_req) // R02
      else $error("dma request disagrees with fifo count");

   property p_take_bits;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      take |=> nbits_q == $past(nbits_q) - {2'h0, $past(w)};
   endproperty
   a_take_bits: assert property (p_take_bits) // R03
      else $error("pixel took wrong bit count");

   property p_le_first;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      take && !ctrl_q.mem_order_sel && w == 5'h08 |=>
         s1_raw_q == {16'h0, $past(acc_q[7:0])};
   endproperty
   a_le_first: assert property (p_le_first) // R05
      else $error("little endian pixel not from low bits");

   property p_be_first;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      take && ctrl_q.mem_order_sel && w == 5'h01 |=>
         s1_raw_q == {23'h0, $past(acc_q[63])};
   endproperty
   a_be_first: assert property (p_be_first) // R06
      else $error("big endian pixel not from high bits");

   property p_refill;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      pop_go |=> ##1 nbits_q == $past(nbits_q, 2) + 7'h20;
   endproperty
   a_refill: assert property (p_refill) // R07
      else $error("word not appended to reservoir");

   property p_tft_pal;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      pix_valid_o && out_tft_pal_q |-> pix_o.data[17:16] == 2'h0 &&
         pix_o.data[9:8] == 2'h0 && pix_o.data[1:0] == 2'h0 &&
         pix_o.data[18] == pix_o.data[10] &&
         pix_o.data[10] == pix_o.data[2];
   endproperty
   a_tft_pal: assert property (p_tft_pal) // R18 R19
      else $error("tft palette output lines wrong");

   property p_mono_pal;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      pix_valid_o && out_mono_pal_q |-> pix_o.data[23:4] == 20'h0;
   endproperty
   a_mono_pal: assert property (p_mono_pal) // R15
      else $error("mono gray wider than four bits");

   property p_bus_ack;
      @(posedge ref_clk_i) disable iff (!reset_n_i)
      bus_st_q == LPS_BUS_IDLE && wb_cyc_i && wb_stb_i |=>
         !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_bus_ack: assert property (p_bus_ack) // R11
      else $error("bus answer not two cycles after request");
endmodule : lps_top
`default_nettype wire

/* testbench/lps_sink.sv */
// downstream pixel sink model with selectable back-pressure
`timescale 1ns/1ps
`default_nettype none
module lps_sink
   import lps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] mode_i,
   input wire logic valid_i,
   input wire lps_pix_s pix_i,
   output logic ready_o,
   output logic got_o,
   output lps_pix_s got_pix_o
);
   // mode 0 stalls, 1 always takes, 2 takes at random
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_o <= 1'b0;
         got_o <= 1'b0;
         got_pix_o <= '0;
      end else begin
         ready_o <= (mode_i == 2'h1) ||
                    (mode_i == 2'h2 && $urandom_range(1, 0) == 1);
         got_o <= valid_i && ready_o;
         got_pix_o <= pix_i;
      end
   end
endmodule : lps_sink
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench of the pixel serializer and palette block
`timescale 1ns/1ps
`default_nettype none
`include "lps_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench
   import lps_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'h0;
   logic dma_push_i = 1'b0, dma_panel_i = 1'b0;
   logic [31:0] dma_data_i = 32'h0;
   logic [1:0] snk_mode = 2'h0;
   wire logic wb_ack_o, pix_valid_o, pix_ready_i, got;
   wire logic [31:0] wb_dat_o;
   wire logic [1:0] fifo_full_o, dma_req_o;
   wire lps_pix_s pix_o, got_pix;
   int errors = 0;
   int checks = 0;
   logic [15:0] lut_m [256];
   logic [31:0] wds [3];
   lps_pix_s exp_q [$];
   lps_pix_s exp_p;

   lps_top lps_top_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .dma_push_i(dma_push_i),
      .dma_panel_i(dma_panel_i), .dma_data_i(dma_data_i),
      .fifo_full_o(fifo_full_o), .dma_req_o(dma_req_o),
      .pix_valid_o(pix_valid_o), .pix_o(pix_o), .pix_ready_i(pix_ready_i));
   lps_sink lps_sink_i (.clk_i(ref_clk_i), .rst_n_i(reset_n_i),
      .mode_i(snk_mode), .valid_i(pix_valid_o), .pix_i(pix_o),
      .ready_o(pix_ready_i), .got_o(got), .got_pix_o(got_pix));

   initial begin
      forever #2 ref_clk_i = ~ref_clk_i;
   end

   task automatic give_verdict();
      if (errors == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic wb(input logic we, input logic [11:0] a,
         input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      if (n >= 50) `CHK(wb_ack_o, 1'b1)
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hf, q);
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, 4'hf, q);
   endtask : rd

   task automatic cfg(input logic en, input logic dual, input logic big,
         input logic [2:0] c, input logic [1:0] t, input logic [8:0] thr);
      lps_ctrl_s r;
      r = '0;
      r.enable = en;
      r.dual_scan = dual;
      r.mem_order_sel = big;
      r.pixel_width_sel = c;
      r.panel_type_sel = t;
      r.fifo_fill_threshold = thr;
      wr(`LPS_ADR_CTRL, r);
   endtask : cfg

   task automatic push(input logic p, input logic [31:0] d);
      @(posedge ref_clk_i);
      dma_push_i <= 1'b1;
      dma_panel_i <= p;
      dma_data_i <= d;
   endtask : push

   task automatic idle(input int n);
      @(posedge ref_clk_i);
      dma_push_i <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
   endtask : idle

   function automatic int pw(input logic [2:0] c);
      return (c == `LPS_PW_24) ? 24 : (1 << c);
   endfunction : pw

   // pixel k of the three-word stream, first pixel at low or high end
   function automatic logic [23:0] pick(input logic big, input int w,
         input int k);
      logic [23:0] v;
      int i;
      v = '0;
      for (int j = 0; j < w; j++) begin
         i = k * w + j;
         if (big)
            v[w-1-j] = wds[i/32][31-i%32];
         else
            v[j] = wds[i/32][i%32];
      end
      return v;
   endfunction : pick

   function automatic logic [23:0] fmt(input logic [1:0] t,
         input logic [2:0] c, input logic [23:0] raw);
      logic [15:0] e;
      e = lut_m[raw[7:0]];
      if (t == `LPS_TYPE_TFT && c <= `LPS_PW_8)
         return {e[14:10], e[15], 2'h0, e[9:5], e[15], 2'h0,
                 e[4:0], e[15], 2'h0};
      if (t == `LPS_TYPE_MONO && c <= `LPS_PW_2)
         return {20'h0, e[4:1]};
      if (t == `LPS_TYPE_COLOR && c <= `LPS_PW_8)
         return {12'h0, e[14:11], e[9:6], e[4:1]};
      return raw;
   endfunction : fmt

   always @(posedge ref_clk_i) begin
      if (got === 1'b1) begin
         if (exp_q.size() == 0)
            `CHK(got, 1'b0)
         else begin
            exp_p = exp_q.pop_front();
            `CHK(got_pix, exp_p)
         end
      end
   end

   task automatic run_mode(input logic [1:0] t, input logic [2:0] c,
         input logic big);
      int n;
      cfg(1'b0, 1'b0, big, c, t, 9'h010);
      cfg(1'b1, 1'b0, big, c, t, 9'h010);
      for (int i = 0; i < 3; i++)
         wds[i] = $urandom();
      for (int k = 0; k < 96 / pw(c); k++)
         exp_q.push_back({1'b0, fmt(t, c, pick(big, pw(c), k))});
      for (int i = 0; i < 3; i++)
         push(1'b0, wds[i]);
      idle(0);
      n = 0;
      while (exp_q.size() > 0 && n < 2000) begin
         @(posedge ref_clk_i);
         n++;
      end
      repeat (8) @(posedge ref_clk_i);
      `CHK(exp_q.size(), 0)
   endtask : run_mode

   initial begin
      logic [31:0] q;
      logic [8:0] thr;
      int n;
      void'($urandom(68));
      repeat (6) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      rd(`LPS_ADR_CTRL, q);
      `CHK(q, `LPS_CTRL_RESET)
      // palette: fill all entries with junk in the upper half
      for (int i = 0; i < 256; i++) begin
         q = $urandom();
         if (i == 0) q = 32'hffff_ffff;
         lut_m[i] = q[15:0];
         wr(12'h400 + 12'(i * 4), q);
      end
      wb(1'b1, 12'h41c, ~{16'h0, lut_m[7]}, 4'h3, q);
      foreach (lut_m[i]) begin
         if (i < 2 || i > 253 || i == 7 || $urandom_range(7, 0) == 0) begin
            rd(12'h400 + 12'(i * 4), q);
            `CHK(q, {16'h0, lut_m[i]})
         end
      end
      rd(12'h100, q);
      `CHK(q, 32'h0)
      // single scan fills to full depth with the sink stalled
      cfg(1'b1, 1'b0, 1'b0, `LPS_PW_8, `LPS_TYPE_TFT, 9'h1ff);
      idle(3);
      `CHK(dma_req_o[0], 1'b1)
      n = 0;
      while (fifo_full_o[0] !== 1'b1 && n < 600) begin
         push(1'b0, $urandom());
         n++;
      end
      idle(3);
      rd(`LPS_ADR_STAT, q);
      `CHK(q[9:0], 10'h200)
      `CHK(q[31:28], 4'h4)
      `CHK(fifo_full_o[0], 1'b1)
      `CHK(dma_req_o[0], 1'b0)
      // dual scan: lower panel alone, threshold boundary
      thr = 9'($urandom_range(256, 1));
      // flush in single scan first, full count must not meet half depth
      cfg(1'b0, 1'b0, 1'b0, `LPS_PW_8, `LPS_TYPE_TFT, thr);
      cfg(1'b1, 1'b1, 1'b0, `LPS_PW_8, `LPS_TYPE_TFT, thr);
      for (int k = 1; k <= 256; k++) begin
         push(1'b1, $urandom());
         idle(3);
         `CHK(dma_req_o[1], 1'(k < thr))
      end
      rd(`LPS_ADR_STAT, q);
      `CHK(q[25:16], 10'h100)
      `CHK(q[31:28], 4'h9)
      `CHK(fifo_full_o[1], 1'b1)
      snk_mode <= 2'h2;
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c <= 5; c++)
            run_mode(`LPS_TYPE_TFT, 3'(c), 1'(b));
         for (int c = 0; c <= 2; c++)
            run_mode(`LPS_TYPE_MONO, 3'(c), 1'(b));
         for (int c = 0; c <= 4; c++)
            run_mode(`LPS_TYPE_COLOR, 3'(c), 1'(b));
      end
      give_verdict();
   end

   initial begin
      repeat (100000) @(posedge ref_clk_i);
      errors++;
      give_verdict();
   end
endmodule : testbench
`default_nettype wire
